/* File: logic/meas_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// RL1: on function change request, latch control byte 0 as output-zero function.
// RL2: host rewrites old function values to discard pending changes.
// RL3: output zero is driven only while its enable bit is set.
// RL4: output one is driven only while its enable bit is set.
// RL5: general gate stop closes the internal counting gate.
// RL6: low-limit load bit loads the supplied low limit.
// RL7: after restart, ignore all control and data until acknowledge is set.
// RL8: host sets acknowledge on request with done clear, clears it after.
// RL9: error acknowledge acknowledges error; reported error details become invalid.
// RL10: host reads error details before acknowledging.
// RL11: status reset clears overflow, underflow and measurement-end flags.
// RL12: output zero follows force bit when reaction inactive and enabled.
// RL13: output one follows force bit when reaction inactive and enabled.
// RL14: software gate opens while its bit is set, closes when cleared.
// RL15: high-limit load bit loads the supplied high limit.
// RL16: refresh-time load bit loads the supplied refresh interval.
// RL17: host never sets load bits together with function change bit.
// RL18: restart request clears on acknowledge rising edge; commands then accepted.
// RL19: no new errors while error flag set; flag clears when ack cleared.
// RL20: each newly set load or reset bit acts once per setting.
module meas_ctrl (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // host control area
    input  wire meas_ctrl_pkg::ctrl_t  ctrl,
    // events from the counting core
    input  wire meas_ctrl_pkg::event_t evt,
    // checkback state and loaded values
    output meas_ctrl_pkg::status_t     status,
    output meas_ctrl_pkg::values_t     values
);

    // ------------------------------------------------------------------
    // command edges
    // ------------------------------------------------------------------
    logic [meas_ctrl_pkg::CMD_W-1:0] cmd_lvl;
    logic [meas_ctrl_pkg::CMD_W-1:0] cmd_rise;
    logic [meas_ctrl_pkg::CMD_W-1:0] cmd_fall;

    // pack the one-shot command bits for edge detection
    always_comb begin
        cmd_lvl = '0;
        cmd_lvl[meas_ctrl_pkg::CMD_LOW_LOAD]  = ctrl.low_limit_load;
        cmd_lvl[meas_ctrl_pkg::CMD_HIGH_LOAD] = ctrl.high_limit_load;
        cmd_lvl[meas_ctrl_pkg::CMD_REFR_LOAD] = ctrl.refresh_time_load;
        cmd_lvl[meas_ctrl_pkg::CMD_STS_RESET] = ctrl.status_flags_reset;
        cmd_lvl[meas_ctrl_pkg::CMD_FUNC_CHG]  =
            ctrl.output_zero_function_change;
        cmd_lvl[meas_ctrl_pkg::CMD_RST_ACK]   = ctrl.restart_acknowledge;
        cmd_lvl[meas_ctrl_pkg::CMD_ERR_ACK]   =
            ctrl.operator_error_acknowledge;
    end

    edge_detect #(
        .W     (meas_ctrl_pkg::CMD_W)
    ) u_cmd_edge (
        .clk   (clk),
        .rst_n (rst_n),
        .level (cmd_lvl),
        .rise  (cmd_rise),
        .fall  (cmd_fall)
    );

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    meas_ctrl_pkg::status_t st_r;
    meas_ctrl_pkg::status_t st_nxt;
    meas_ctrl_pkg::values_t val_r;
    meas_ctrl_pkg::values_t val_nxt;
    logic                   err_acked_r;
    logic                   err_acked_nxt;
    logic                   accept;
    logic                   out0_inactive;

    // commands count only once the restart handshake is done
    assign accept = st_r.restart_ack_done_flag; // see RL7
    assign out0_inactive =
        val_r.output_zero_function[meas_ctrl_pkg::FUNC_CMP_LSB +: 2]
        == meas_ctrl_pkg::CMP_NONE;

    // restart handshake
    always_comb begin
        st_nxt = st_r;
        if (st_r.restart_request_flag &&
            cmd_rise[meas_ctrl_pkg::CMD_RST_ACK]) begin
            st_nxt.restart_request_flag  = 1'b0; // see RL18
            st_nxt.restart_ack_done_flag = 1'b1;
        end
        // status flags: a core event wins over a same-cycle reset
        if (accept && cmd_rise[meas_ctrl_pkg::CMD_STS_RESET]) begin
            st_nxt.overflow_flag        = 1'b0; // see RL11
            st_nxt.underflow_flag       = 1'b0;
            st_nxt.measurement_end_flag = 1'b0;
        end
        if (evt.overflow) begin
            st_nxt.overflow_flag = 1'b1;
        end
        if (evt.underflow) begin
            st_nxt.underflow_flag = 1'b1;
        end
        if (evt.measurement_end) begin
            st_nxt.measurement_end_flag = 1'b1;
        end
        // operator error: ack invalidates details, release clears flag
        if (st_r.operator_error_flag && err_acked_r &&
            cmd_fall[meas_ctrl_pkg::CMD_ERR_ACK]) begin
            st_nxt.operator_error_flag = 1'b0; // see RL19
        end
        if (accept && st_r.operator_error_flag &&
            cmd_rise[meas_ctrl_pkg::CMD_ERR_ACK]) begin
            st_nxt.error_code = meas_ctrl_pkg::ERR_CODE_RST; // see RL9
        end
        if (accept && evt.operator_error && !st_r.operator_error_flag) begin
            st_nxt.operator_error_flag = 1'b1; // see RL19
            st_nxt.error_code          = evt.error_code;
        end
        // gates: frozen closed until accepted
        st_nxt.software_gate_open = accept && ctrl.software_gate; // see RL14
        st_nxt.internal_gate_open = accept && ctrl.software_gate &&
                                    !ctrl.internal_gate_stop; // see RL5
        // outputs
        if (!accept || !ctrl.output_zero_enable) begin
            st_nxt.digital_output_zero = 1'b0; // see RL3
        end else if (out0_inactive) begin
            st_nxt.digital_output_zero = ctrl.output_zero_force; // see RL12
        end else begin
            st_nxt.digital_output_zero = evt.compare_zero;
        end
        if (!accept || !ctrl.output_one_enable) begin
            st_nxt.digital_output_one = 1'b0; // see RL4
        end else if (evt.output_one_inactive) begin
            st_nxt.digital_output_one = ctrl.output_one_force; // see RL13
        end else begin
            st_nxt.digital_output_one = evt.compare_one;
        end
    end

    // acknowledge seen while the error flag stood
    always_comb begin
        err_acked_nxt = err_acked_r;
        if (!st_r.operator_error_flag) begin
            err_acked_nxt = 1'b0;
        end else if (accept && cmd_rise[meas_ctrl_pkg::CMD_ERR_ACK]) begin
            err_acked_nxt = 1'b1;
        end
    end

    // value loads, one per newly set bit
    always_comb begin
        val_nxt = val_r;
        if (accept && cmd_rise[meas_ctrl_pkg::CMD_LOW_LOAD]) begin
            val_nxt.low_limit = ctrl.low_limit; // see RL6, RL20
        end
        if (accept && cmd_rise[meas_ctrl_pkg::CMD_HIGH_LOAD]) begin
            val_nxt.high_limit = ctrl.high_limit; // see RL15
        end
        if (accept && cmd_rise[meas_ctrl_pkg::CMD_REFR_LOAD]) begin
            val_nxt.refresh_time = ctrl.refresh_time; // see RL16
        end
        if (accept && cmd_rise[meas_ctrl_pkg::CMD_FUNC_CHG]) begin
            val_nxt.output_zero_function = ctrl.output_zero_function; // see RL1
        end
    end

    // register everything; restart raises the request flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r                       <= '0;
            st_r.restart_request_flag  <= 1'b1;
            st_r.error_code            <= meas_ctrl_pkg::ERR_CODE_RST;
            val_r.low_limit            <= meas_ctrl_pkg::LIMIT_RST;
            val_r.high_limit           <= meas_ctrl_pkg::LIMIT_RST;
            val_r.refresh_time         <= meas_ctrl_pkg::REFR_RST;
            val_r.output_zero_function <= meas_ctrl_pkg::FUNC_RST;
            err_acked_r                <= 1'b0;
        end else begin
            st_r        <= st_nxt;
            val_r       <= val_nxt;
            err_acked_r <= err_acked_nxt;
        end
    end

    assign status = st_r;
    assign values = val_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_out_zero_enable: assert property ( // see RL3
        !ctrl.output_zero_enable |=> !status.digital_output_zero)
        else $error("output zero driven while disabled");

    a_out_one_enable: assert property ( // see RL4
        !ctrl.output_one_enable |=> !status.digital_output_one)
        else $error("output one driven while disabled");

    a_gate_stop_closes: assert property ( // see RL5
        ctrl.internal_gate_stop |=> !status.internal_gate_open)
        else $error("internal gate open under stop");

    a_low_limit_load: assert property ( // see RL6
        accept && cmd_rise[meas_ctrl_pkg::CMD_LOW_LOAD]
        |=> values.low_limit == $past(ctrl.low_limit))
        else $error("low limit not loaded");

    a_ignore_before_ack: assert property ( // see RL7
        !accept |=> $stable(values) || $past(accept))
        else $error("value loaded before restart acknowledge");

    a_restart_ack_edge: assert property ( // see RL18
        status.restart_request_flag && $rose(ctrl.restart_acknowledge)
        |=> !status.restart_request_flag && status.restart_ack_done_flag)
        else $error("restart request not cleared on acknowledge");

    a_status_reset: assert property ( // see RL11
        accept && cmd_rise[meas_ctrl_pkg::CMD_STS_RESET] && !evt.overflow
        |=> !status.overflow_flag)
        else $error("overflow flag survived status reset");

    a_force_zero: assert property ( // see RL12
        accept && ctrl.output_zero_enable && out0_inactive
        |=> status.digital_output_zero == $past(ctrl.output_zero_force))
        else $error("output zero not following force bit");

    a_soft_gate: assert property ( // see RL14
        accept && ctrl.software_gate |=> status.software_gate_open)
        else $error("software gate not open");

    // an acknowledge rise itself voids the code, so it is left out here
    a_error_held: assert property ( // see RL19
        status.operator_error_flag && !err_acked_r &&
        !cmd_rise[meas_ctrl_pkg::CMD_ERR_ACK]
        |=> status.operator_error_flag &&
            $stable(status.error_code))
        else $error("operator error changed while pending");

    a_load_once: assert property ( // see RL20
        accept && cmd_rise[meas_ctrl_pkg::CMD_HIGH_LOAD]
        ##1 ctrl.high_limit_load [*2] |-> $stable(values.high_limit))
        else $error("held load bit acted twice");

    c_restart_done: cover property (
        $rose(status.restart_ack_done_flag));
    c_error_cycle: cover property (
        $rose(status.operator_error_flag) ##[1:50]
        $fell(status.operator_error_flag));
    c_forced_out: cover property (
        out0_inactive && $rose(status.digital_output_zero));

endmodule

`default_nettype wire

/* File: include/meas_ctrl_pkg.sv */
package meas_ctrl_pkg;

    // ------------------------------------------------------------------
    // command bit positions in the edge-detected command vector
    // ------------------------------------------------------------------
    localparam int CMD_W          = 7;
    localparam int CMD_LOW_LOAD   = 0;
    localparam int CMD_HIGH_LOAD  = 1;
    localparam int CMD_REFR_LOAD  = 2;
    localparam int CMD_STS_RESET  = 3;
    localparam int CMD_FUNC_CHG   = 4;
    localparam int CMD_RST_ACK    = 5;
    localparam int CMD_ERR_ACK    = 6;

    // ------------------------------------------------------------------
    // output-zero function byte layout and reset values
    // ------------------------------------------------------------------
    localparam int        FUNC_CMP_LSB   = 0;
    localparam logic [1:0] CMP_NONE      = 2'h0;
    localparam logic [7:0] FUNC_RST      = 8'h00;
    localparam logic [31:0] LIMIT_RST    = 32'h0000_0000;
    localparam logic [15:0] REFR_RST     = 16'h0000;
    localparam logic [7:0] ERR_CODE_RST  = 8'h00;

    // host control area
    typedef struct packed {
        logic [31:0] low_limit;
        logic [31:0] high_limit;
        logic [15:0] refresh_time;
        logic [7:0]  output_zero_function;
        logic        output_zero_function_change;
        logic        status_flags_reset;
        logic        refresh_time_load;
        logic        high_limit_load;
        logic        low_limit_load;
        logic        output_zero_enable;
        logic        output_one_enable;
        logic        output_zero_force;
        logic        output_one_force;
        logic        software_gate;
        logic        internal_gate_stop;
        logic        restart_acknowledge;
        logic        operator_error_acknowledge;
    } ctrl_t;

    // events reported by the counting core
    typedef struct packed {
        logic       overflow;
        logic       underflow;
        logic       measurement_end;
        logic       operator_error;
        logic [7:0] error_code;
        logic       compare_zero;
        logic       compare_one;
        logic       output_one_inactive;
    } event_t;

    // checkback state
    typedef struct packed {
        logic        restart_request_flag;
        logic        restart_ack_done_flag;
        logic        operator_error_flag;
        logic [7:0]  error_code;
        logic        overflow_flag;
        logic        underflow_flag;
        logic        measurement_end_flag;
        logic        software_gate_open;
        logic        internal_gate_open;
        logic        digital_output_zero;
        logic        digital_output_one;
    } status_t;

    // values handed to the counting core
    typedef struct packed {
        logic [31:0] low_limit;
        logic [31:0] high_limit;
        logic [15:0] refresh_time;
        logic [7:0]  output_zero_function;
    } values_t;

endpackage

/* File: logic/edge_detect.sv */
`timescale 1ns/1ns
`default_nettype none

module edge_detect #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // level in, one-cycle edges out
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    logic [W-1:0] prev_r;
    logic [W-1:0] prev_nxt;

    // previous level tracked always so a held bit counts once
    always_comb begin
        prev_nxt = level;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_r <= '0;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    assign rise = level & ~prev_r;
    assign fall = ~level & prev_r;

endmodule

`default_nettype wire

/* File: sim/host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// host side of the restart handshake, driven off the falling edge
module host_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // handshake enable from the bench
    input  wire logic go,
    // checkback flags
    input  wire logic restart_request_flag,
    input  wire logic restart_ack_done_flag,
    // acknowledge level to the device
    output var  logic restart_acknowledge
);
    logic ask;
    logic done;

    // ------------------------------------------------------------------
    // restart acknowledge handshake
    // ------------------------------------------------------------------
    // go lets the bench keep the device in its ignoring state for a while
    assign ask  = go && restart_request_flag && !restart_ack_done_flag;
    assign done = !restart_request_flag && restart_ack_done_flag;

    initial restart_acknowledge = 1'b0;

    // set on request, drop once the device reports it done
    always @(negedge clk) begin
        if (!rst_n) begin
            restart_acknowledge <= 1'b0;
        end else if (ask) begin
            restart_acknowledge <= 1'b1;
        end else if (done) begin
            restart_acknowledge <= 1'b0;
        end
    end
endmodule

`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic                  clk;
    logic                  rst_n;
    logic                  go;
    logic                  ack;
    meas_ctrl_pkg::ctrl_t  c;
    meas_ctrl_pkg::ctrl_t  ci;
    meas_ctrl_pkg::event_t e;
    meas_ctrl_pkg::status_t s;
    meas_ctrl_pkg::values_t v;
    int                    fails;
    int                    checks_done;
    int                    n;

    // ------------------------------------------------------------------
    // clock, partner and device
    // ------------------------------------------------------------------
    always #25 clk = ~clk;

    // the acknowledge bit belongs to the host model, the rest to the bench
    always_comb begin
        ci = c;
        ci.restart_acknowledge = ack;
    end

    host_model host_u (
        .clk                   (clk),
        .rst_n                 (rst_n),
        .go                    (go),
        .restart_request_flag  (s.restart_request_flag),
        .restart_ack_done_flag (s.restart_ack_done_flag),
        .restart_acknowledge   (ack)
    );

    meas_ctrl dut_u (
        .clk    (clk),
        .rst_n  (rst_n),
        .ctrl   (ci),
        .evt    (e),
        .status (s),
        .values (v)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask

    // case inequality so an unknown never passes
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        go = 1'b0;
        c = '0;
        e = '0;
        fails = 0;
        checks_done = 0;
        tick(6);
        rst_n = 1'b1;
        check("req", s.restart_request_flag, 1);
        check("done", s.restart_ack_done_flag, 0);
        // commands before the acknowledge must be ignored
        c.low_limit = 32'h0000_1234;
        c.low_limit_load = 1'b1;
        c.software_gate = 1'b1;
        c.output_zero_enable = 1'b1;
        c.output_zero_force = 1'b1;
        tick(2);
        check("low early", v.low_limit, 0);
        check("gate early", s.software_gate_open, 0);
        check("do0 early", s.digital_output_zero, 0);
        c.low_limit_load = 1'b0;
        tick(1);
        // restart handshake, bounded wait
        go = 1'b1;
        n = 0;
        while (s.restart_ack_done_flag !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        if (n == 20) begin
            fails++;
            complete_run();
        end
        check("req clr", s.restart_request_flag, 0);
        tick(2);
        check("gate open", s.software_gate_open, 1);
        check("do0 force", s.digital_output_zero, 1);
        check("do1 off", s.digital_output_one, 0);
        // back to back loads on different bits, never with function change
        c.low_limit_load = 1'b1;
        tick(1);
        check("low", v.low_limit, 32'h0000_1234);
        c.low_limit = 32'h0000_5678;
        c.high_limit = 32'hdead_beef;
        c.high_limit_load = 1'b1;
        tick(1);
        check("high", v.high_limit, 32'hdead_beef);
        check("low held", v.low_limit, 32'h0000_1234);
        c.refresh_time = 16'h0abc;
        c.refresh_time_load = 1'b1;
        tick(1);
        check("refresh", v.refresh_time, 32'h0000_0abc);
        c.low_limit_load = 1'b0;
        c.high_limit_load = 1'b0;
        c.refresh_time_load = 1'b0;
        // function change to a comparing reaction, force then ignored
        c.output_zero_function = 8'h01;
        c.output_zero_function_change = 1'b1;
        tick(1);
        check("func", v.output_zero_function, 32'h0000_0001);
        tick(1);
        check("do0 cmp", s.digital_output_zero, 0);
        e.compare_zero = 1'b1;
        tick(2);
        check("do0 cmp on", s.digital_output_zero, 1);
        e.compare_zero = 1'b0;
        // discard by rewriting the old function before changing again
        c.output_zero_function_change = 1'b0;
        c.output_zero_function = 8'h00;
        tick(1);
        c.output_zero_function_change = 1'b1;
        tick(2);
        check("func old", v.output_zero_function, 0);
        check("do0 back", s.digital_output_zero, 1);
        c.output_zero_function_change = 1'b0;
        // output one forced, then comparing, then disabled
        c.output_one_enable = 1'b1;
        c.output_one_force = 1'b1;
        e.output_one_inactive = 1'b1;
        tick(2);
        check("do1 force", s.digital_output_one, 1);
        e.output_one_inactive = 1'b0;
        tick(2);
        check("do1 cmp", s.digital_output_one, 0);
        e.compare_one = 1'b1;
        tick(2);
        check("do1 cmp on", s.digital_output_one, 1);
        c.output_one_enable = 1'b0;
        c.output_zero_enable = 1'b0;
        tick(2);
        check("do1 dis", s.digital_output_one, 0);
        check("do0 dis", s.digital_output_zero, 0);
        // gates
        check("int open", s.internal_gate_open, 1);
        c.internal_gate_stop = 1'b1;
        tick(2);
        check("int stop", s.internal_gate_open, 0);
        check("sw kept", s.software_gate_open, 1);
        c.software_gate = 1'b0;
        tick(2);
        check("sw shut", s.software_gate_open, 0);
        // status flags set by events, cleared by one reset rise
        e.overflow = 1'b1;
        e.underflow = 1'b1;
        e.measurement_end = 1'b1;
        tick(1);
        e.overflow = 1'b0;
        e.underflow = 1'b0;
        e.measurement_end = 1'b0;
        tick(1);
        check("ovf set", s.overflow_flag, 1);
        c.status_flags_reset = 1'b1;
        tick(2);
        check("ovf clr", s.overflow_flag, 0);
        check("ufl clr", s.underflow_flag, 0);
        check("end clr", s.measurement_end_flag, 0);
        e.overflow = 1'b1;
        tick(1);
        e.overflow = 1'b0;
        tick(1);
        check("ovf held", s.overflow_flag, 1);
        // operator error, a second one while pending, then acknowledge
        e.operator_error = 1'b1;
        e.error_code = 8'h05;
        tick(1);
        e.operator_error = 1'b0;
        tick(1);
        check("err flag", s.operator_error_flag, 1);
        check("err code", s.error_code, 32'h0000_0005);
        e.operator_error = 1'b1;
        e.error_code = 8'h09;
        tick(1);
        e.operator_error = 1'b0;
        tick(1);
        check("err kept", s.error_code, 32'h0000_0005);
        c.operator_error_acknowledge = 1'b1;
        tick(2);
        check("err void", s.error_code, 0);
        check("err stays", s.operator_error_flag, 1);
        c.operator_error_acknowledge = 1'b0;
        tick(2);
        check("err gone", s.operator_error_flag, 0);
        complete_run();
    end
endmodule

`default_nettype wire
